// ===== common/smsp_pkg.sv
// Constants, types and state record of the serial port controller
package smsp_pkg;

  // ------------------------------------------------------------------
  // Register map: indices, byte address is four times the index
  // ------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_CONTROL = 8'h2C;
  localparam logic [7:0] IDX_STATUS = 8'h2D;
  localparam logic [7:0] IDX_DATA = 8'h2E;
  localparam logic [7:0] IDX_PIN_CFG = 8'h2F;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_DATA = {IDX_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PIN_CFG = {IDX_PIN_CFG, 2'b00};

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_PORT_EN = 6;
  localparam int CTL_ORDER = 5;
  localparam int CTL_ROLE = 4;
  localparam int CTL_CLOCK_IDLE_POLARITY = 3;
  localparam int CTL_CLOCK_SAMPLE_PHASE = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  localparam int STS_TCF = 7;
  localparam int STS_WCF = 6;
  localparam int STS_DBL = 0;
  localparam int PCF_SS_IN = 0;

  // ------------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------------
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic PIN_CFG_SS_IN_RST = 1'b1;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  // Half periods of the master clock, minus one, in system clocks
  localparam logic [6:0] HALF_M1_DIV4 = 7'h01;
  localparam logic [6:0] HALF_M1_DIV16 = 7'h07;
  localparam logic [6:0] HALF_M1_DIV64 = 7'h1F;
  localparam logic [6:0] HALF_M1_DIV128 = 7'h3F;
  localparam logic [6:0] HALF_M1_DIV2 = 7'h00;
  localparam logic [6:0] HALF_M1_DIV8 = 7'h03;
  localparam logic [6:0] HALF_M1_DIV32 = 7'h0F;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MASTER = 3'b010,
    ST_SLAVE = 3'b100
  } smsp_state_e;

  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic mosi_o;
    logic mosi_oe_n;
    logic miso_o;
    logic miso_oe_n;
  } smsp_pins_s;

  typedef struct packed {
    smsp_state_e st;
    logic [7:0] ctrl;
    logic dbl;
    logic tcf;
    logic wcf;
    logic arm_tcf;
    logic arm_wcf;
    logic ss_in_cfg;
    logic [7:0] shreg;
    logic [7:0] rxbuf;
    logic [3:0] ecnt;
    logic [6:0] div;
    logic sck_lvl;
    logic out_bit;
    logic [7:0] prdata;
    logic slverr;
    logic irq;
    logic ss_s1;
    logic ss_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_prev;
    logic mosi_s1;
    logic mosi_s2;
    logic miso_s1;
    logic miso_s2;
  } smsp_state_s;

endpackage

// ===== logic/smsp_port.sv
// Serial peripheral port controller, master or slave, with APB registers
`timescale 1ns/1ps
module smsp_port
  import smsp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor side
  input wire logic global_irq_en,
  input wire logic vector_taken,
  output logic xfer_irq,
  // Serial pins
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_n_i,
  output smsp_pins_s pins
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  smsp_state_s s_r; // Whole register state
  smsp_state_s s_nxt; // Next value of it
  logic en; // Port enabled
  logic role; // One for master
  logic clock_idle_polarity; // Idle clock level
  logic clock_sample_phase; // Sample on trailing edge
  logic lsb_first; // Bit order
  logic acc; // APB access completes this edge
  logic wr; // Completing write
  logic rd; // Completing read
  logic hit_ctl; // Address decode
  logic hit_sts;
  logic hit_dat;
  logic hit_pcf;
  logic busy; // Transfer under way
  logic load; // Shifter loaded from software
  logic step; // A clock edge acts this cycle
  logic lead; // That edge is the leading one
  logic sample; // That edge samples data
  logic sin; // Serial data being sampled
  logic [7:0] sh_in; // Shifter with the sampled bit in
  logic [6:0] half_m1; // Half period count for master
  logic fault; // Master deselected by another master
  logic tcf_set; // Done flag set this cycle

  assign en = s_r.ctrl[CTL_PORT_EN];
  assign role = s_r.ctrl[CTL_ROLE];
  assign clock_idle_polarity = s_r.ctrl[CTL_CLOCK_IDLE_POLARITY];
  assign clock_sample_phase = s_r.ctrl[CTL_CLOCK_SAMPLE_PHASE];
  assign lsb_first = s_r.ctrl[CTL_ORDER];

  // ------------------------------------------------------------------
  // Bus answer
  // ------------------------------------------------------------------
  // Zero wait states: read data was captured in the setup cycle
  assign pready = psel & penable;
  assign prdata = {24'h000000, s_r.prdata};
  assign pslverr = s_r.slverr;
  assign xfer_irq = s_r.irq;

  // ------------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------------
  // Master drives clock and data out; slave drives its output only while selected
  always_comb begin
    pins.sck_o = s_r.sck_lvl;
    pins.sck_oe_n = ~(en & role);
    pins.mosi_o = s_r.out_bit;
    pins.mosi_oe_n = ~(en & role);
    pins.miso_o = s_r.out_bit;
    pins.miso_oe_n = ~(s_r.st == ST_SLAVE);
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Pin synchronisers; the external clock is only sampled, so its phases
    // must each outlast one system clock or edges are missed
    s_nxt.ss_s1 = ss_n_i;
    s_nxt.ss_s2 = s_r.ss_s1;
    s_nxt.sck_s1 = sck_i;
    s_nxt.sck_s2 = s_r.sck_s1;
    s_nxt.sck_prev = s_r.sck_s2;
    s_nxt.mosi_s1 = mosi_i;
    s_nxt.mosi_s2 = s_r.mosi_s1;
    s_nxt.miso_s1 = miso_i;
    s_nxt.miso_s2 = s_r.miso_s1;

    acc = psel & penable;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    hit_ctl = (paddr == ADDR_CONTROL);
    hit_sts = (paddr == ADDR_STATUS);
    hit_dat = (paddr == ADDR_DATA);
    hit_pcf = (paddr == ADDR_PIN_CFG);
    busy = (s_r.st == ST_MASTER) || ((s_r.st == ST_SLAVE) && (s_r.ecnt != 4'h0));
    load = 1'b0;
    step = 1'b0;
    lead = 1'b0;
    sin = 1'b0;
    tcf_set = 1'b0;
    fault = en & role & s_r.ss_in_cfg & ~s_r.ss_s2;

    // Master clock rate from rate code and double speed
    case ({s_r.dbl, s_r.ctrl[CTL_RATE_HI], s_r.ctrl[CTL_RATE_LO]})
      3'b000: half_m1 = HALF_M1_DIV4;
      3'b001: half_m1 = HALF_M1_DIV16;
      3'b010: half_m1 = HALF_M1_DIV64;
      3'b011: half_m1 = HALF_M1_DIV128;
      3'b100: half_m1 = HALF_M1_DIV2;
      3'b101: half_m1 = HALF_M1_DIV8;
      3'b110: half_m1 = HALF_M1_DIV32;
      default: half_m1 = HALF_M1_DIV64;
    endcase

    // Setup cycle: capture read data so it comes from a flop
    if (psel && !penable) begin
      s_nxt.slverr = 1'b0;
      if (hit_ctl) begin
        s_nxt.prdata = s_r.ctrl;
      end else if (hit_sts) begin
        s_nxt.prdata = {s_r.tcf, s_r.wcf, 5'h00, s_r.dbl};
      end else if (hit_dat) begin
        s_nxt.prdata = s_r.rxbuf;
      end else if (hit_pcf) begin
        s_nxt.prdata = {7'h00, s_r.ss_in_cfg};
      end else begin
        // Unmapped: zero data and an error answer
        s_nxt.prdata = 8'h00;
        s_nxt.slverr = 1'b1;
      end
    end

    // Register writes
    if (wr && hit_ctl) begin
      s_nxt.ctrl = pwdata[7:0];
    end
    if (wr && hit_sts) begin
      s_nxt.dbl = pwdata[STS_DBL];
    end
    if (wr && hit_pcf) begin
      s_nxt.ss_in_cfg = pwdata[PCF_SS_IN];
    end

    // Flag clearing: status read arms, following data access clears
    if (rd && hit_sts) begin
      s_nxt.arm_tcf = s_r.prdata[STS_TCF];
      s_nxt.arm_wcf = s_r.prdata[STS_WCF];
    end
    if (acc && hit_dat) begin
      if (s_r.arm_tcf || s_r.arm_wcf) begin
        s_nxt.tcf = 1'b0;
      end
      if (s_r.arm_wcf) begin
        s_nxt.wcf = 1'b0;
      end
      s_nxt.arm_tcf = 1'b0;
      s_nxt.arm_wcf = 1'b0;
    end
    if (vector_taken) begin
      s_nxt.tcf = 1'b0;
    end

    // Data write: only one transmit buffer, so a write mid-byte is refused
    if (wr && hit_dat) begin
      if (busy) begin
        s_nxt.wcf = 1'b1;
      end else begin
        load = 1'b1;
      end
    end

    // Transfer sequencing
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.ecnt = 4'h0;
        s_nxt.sck_lvl = clock_idle_polarity;
        if (en && role && load) begin
          // Master starts its clock on the data write
          s_nxt.st = ST_MASTER;
          s_nxt.div = half_m1;
        end else if (en && !role && !s_r.ss_s2) begin
          s_nxt.st = ST_SLAVE;
        end
      end
      ST_MASTER: begin
        if (s_r.div == 7'h00) begin
          s_nxt.div = half_m1;
          s_nxt.sck_lvl = ~s_r.sck_lvl;
          step = 1'b1;
          lead = ~s_r.ecnt[0];
          // Synchroniser delay: at the fastest rates the slave's bit is
          // seen two clocks late, so those rates need a quick slave
          sin = s_r.miso_s2;
        end else begin
          s_nxt.div = s_r.div - 7'h01;
        end
      end
      ST_SLAVE: begin
        if (s_r.ss_s2 || role) begin
          // Deselect drops any partial byte
          s_nxt.st = ST_IDLE;
          s_nxt.ecnt = 4'h0;
        end else if (s_r.sck_s2 != s_r.sck_prev) begin
          // Timing comes from the external clock only
          step = 1'b1;
          lead = (s_r.sck_prev == clock_idle_polarity);
          sin = s_r.mosi_s2;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Edge action: sample on one edge kind, set up on the other
    sample = lead ^ clock_sample_phase;
    sh_in = lsb_first ? {sin, s_r.shreg[7:1]} : {s_r.shreg[6:0], sin};
    if (step) begin
      s_nxt.ecnt = s_r.ecnt + 4'h1;
      if (sample) begin
        s_nxt.shreg = sh_in;
      end else begin
        s_nxt.out_bit = lsb_first ? s_r.shreg[0] : s_r.shreg[7];
      end
      if (s_r.ecnt == LAST_EDGE) begin
        // Sixteen edges carry eight bits each way
        s_nxt.rxbuf = sample ? sh_in : s_r.shreg;
        tcf_set = 1'b1;
        if (s_r.st == ST_MASTER) begin
          s_nxt.st = ST_IDLE;
        end
      end
    end

    if (load) begin
      s_nxt.shreg = pwdata[7:0];
    end
    // Between bytes the first bit is presented ahead of any edge
    if (!step && (s_nxt.ecnt == 4'h0)) begin
      s_nxt.out_bit = lsb_first ? s_nxt.shreg[0] : s_nxt.shreg[7];
    end

    // Disabled port does nothing
    if (!en) begin
      s_nxt.st = ST_IDLE;
      s_nxt.ecnt = 4'h0;
    end
    // Another master took the bus: become slave and report it
    if (fault) begin
      s_nxt.ctrl[CTL_ROLE] = 1'b0;
      s_nxt.st = ST_IDLE;
      s_nxt.ecnt = 4'h0;
      tcf_set = 1'b1;
    end
    // Setting wins over any clear in the same cycle
    if (tcf_set) begin
      s_nxt.tcf = 1'b1;
    end
    s_nxt.irq = s_nxt.tcf & s_nxt.ctrl[CTL_IRQ_EN] & global_irq_en;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.ctrl <= CONTROL_RST;
      s_r.shreg <= DATA_RST;
      s_r.ss_in_cfg <= PIN_CFG_SS_IN_RST;
      s_r.ss_s1 <= 1'b1;
      s_r.ss_s2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_idle_when_off: assert property (!en |=> s_r.st == ST_IDLE)
    else $error("transfer active while port disabled");
  a_lsb_setup_bit: assert property ((s_r.st == ST_MASTER) && step && !sample && lsb_first
    |=> pins.mosi_o == $past(s_r.shreg[0]))
    else $error("wrong bit driven for lsb-first order");
  a_master_needs_role: assert property ((s_r.st == ST_MASTER) |-> role)
    else $error("master transfer without master role");
  a_mode_fault: assert property (fault |=> !role && s_r.tcf && (s_r.st == ST_IDLE))
    else $error("master deselect not handled");
  a_sck_idle_level: assert property ((s_r.st == ST_IDLE) && $past(s_r.st == ST_IDLE) && en && role
    |-> pins.sck_o == $past(clock_idle_polarity))
    else $error("idle clock level wrong");
  a_div4_period: assert property ((s_r.st == ST_MASTER) && (s_r.div == 7'h00) && !s_r.dbl
    && (s_r.ctrl[1:0] == 2'b00) && (s_r.ecnt < 4'hE) && !fault && en
    |=> $changed(pins.sck_o) ##1 $stable(pins.sck_o) ##1 $changed(pins.sck_o))
    else $error("divide by four period wrong");
  a_div2_period: assert property ((s_r.st == ST_MASTER) && (s_r.div == 7'h00) && s_r.dbl
    && (s_r.ctrl[1:0] == 2'b00) && (s_r.ecnt < 4'hE) && !fault && en
    |=> $changed(pins.sck_o) ##1 $changed(pins.sck_o))
    else $error("double speed period wrong");
  a_done_flag: assert property (step && (s_r.ecnt == LAST_EDGE) |=> s_r.tcf && (s_r.ecnt == 4'h0))
    else $error("done flag missing after eighth bit");
  a_irq_request: assert property (s_r.tcf && s_r.ctrl[CTL_IRQ_EN] && global_irq_en && !vector_taken
    && !(acc && hit_dat) |=> xfer_irq)
    else $error("interrupt request missing");
  a_vector_clear: assert property (vector_taken && !tcf_set |=> !s_r.tcf)
    else $error("vector did not clear done flag");
  a_collision: assert property (wr && hit_dat && busy
    |=> s_r.wcf && (s_r.shreg == $past((step && sample) ? sh_in : s_r.shreg)))
    else $error("collision not flagged or shifter overwritten");
  a_reserved_zero: assert property (psel && penable && !pwrite && hit_sts
    |-> prdata[5:1] == 5'h00)
    else $error("reserved status bits not zero");
  a_rx_buffer_read: assert property (psel && !penable && !pwrite && hit_dat
    |=> prdata[7:0] == $past(s_r.rxbuf))
    else $error("data read not from receive buffer");
  a_slave_deselect: assert property ((s_r.st == ST_SLAVE) && s_r.ss_s2
    |=> (s_r.ecnt == 4'h0) && pins.miso_oe_n)
    else $error("slave deselect did not reset");

  c_master_byte: cover property ((s_r.st == ST_MASTER) && step && (s_r.ecnt == LAST_EDGE));
  c_slave_byte: cover property ((s_r.st == ST_SLAVE) && step && (s_r.ecnt == LAST_EDGE));
  c_mode_fault: cover property (fault);
  c_collision: cover property (wr && hit_dat && busy);

endmodule

// ===== verif/smsp_slave_model.sv
// Behavioural far-side slave that answers master-role transfers
`timescale 1ns/1ps
module smsp_slave_model (
  // Serial wires
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Frame setup from the bench
  input wire logic load,
  input wire logic clock_idle_polarity,
  input wire logic clock_sample_phase,
  input wire logic lsb_first,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  int ns = 8; // Sample edges seen, idle until a frame is loaded
  int nu = 0; // Setup edges seen
  int idx; // Bit to present next
  logic ph; // Rising edge of this means sample
  assign ph = sck ^ clock_idle_polarity ^ clock_sample_phase;
  // Bit of a byte in wire order
  function automatic logic pick(input logic [7:0] d, input int i);
    return lsb_first ? d[i] : d[7-i];
  endfunction
  // New frame: first bit must stand before the leading edge
  always @(posedge load) begin
    ns = 0;
    nu = 0;
    miso = pick(tx, 0);
  end
  // Sample edge: capture the master's bit
  always @(posedge ph) begin
    if (ns < 8) begin
      if (lsb_first) rx[ns] = mosi;
      else rx[7-ns] = mosi;
      ns = ns + 1;
      // Last edge is a sample edge: line is inverted at once
      if (clock_sample_phase && ns == 8) miso = ~miso;
    end
  end
  // Setup edge: next bit, or the inverse once the frame is over
  always @(negedge ph) begin
    if (ns < 8 || !clock_sample_phase) begin
      nu = nu + 1;
      idx = clock_sample_phase ? nu - 1 : nu;
      miso = (idx < 8) ? pick(tx, idx) : ~miso;
    end
  end
endmodule

// ===== verif/testbench.sv
// Self-checking bench of the serial port controller in master and slave roles
`timescale 1ns/1ps
module testbench;
  import smsp_pkg::*;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, xfer_irq, miso_w, sck_w;
  logic global_irq_en = 1'b0, vector_taken = 1'b0, ss_n_i = 1'b1;
  logic s_sck = 1'b0, s_mosi = 1'b0; // Far master's clock and data in slave tests
  logic load = 1'b0, m_clock_idle_polarity = 1'b0, m_clock_sample_phase = 1'b0, m_lsb = 1'b0;
  logic [7:0] m_tx = 8'h00, m_rx;
  smsp_pins_s pins;
  int fails = 0, tests_run = 0, tog = 0, cyc = 0;
  int tt [4096]; // Cycle of each clock-line toggle
  logic sck_q = 1'b0;
  // 50 ns period
  always #25 sys_clk = ~sys_clk;
  // Clock line seen by the slave; idles at polarity when undriven
  assign sck_w = pins.sck_oe_n ? m_clock_idle_polarity : pins.sck_o;
  smsp_port smsp_port_inst (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_irq_en(global_irq_en), .vector_taken(vector_taken),
    .xfer_irq(xfer_irq), .sck_i(s_sck), .mosi_i(s_mosi), .miso_i(miso_w), .ss_n_i(ss_n_i),
    .pins(pins));
  smsp_slave_model smsp_slave_model_inst (.sck(sck_w), .mosi(pins.mosi_o), .miso(miso_w),
    .load(load), .clock_idle_polarity(m_clock_idle_polarity), .clock_sample_phase(m_clock_sample_phase), .lsb_first(m_lsb), .tx(m_tx), .rx(m_rx));
  // Toggle monitor on the clock line
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    sck_q <= pins.sck_o;
    if (pins.sck_o !== sck_q) begin
      tt[tog] <= cyc;
      tog <= tog + 1;
    end
  end
  // --------------------------------------------------------------
  // Tasks and expectations
  // --------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("Counts: tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // APB access, held until pready is seen high
  task acc(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] wd,
           output logic [7:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Master clock divisor from double speed and rate code
  function automatic int exp_div(input logic dbl, input logic [1:0] r);
    int t [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    return t[{dbl, r}];
  endfunction
  // One master transfer with optional collision and vector clear
  task xfer(input logic [7:0] c, input logic dbl, input logic [7:0] tx, input logic [7:0] sd,
            input logic coll, input logic vec);
    logic [7:0] s, d;
    logic e;
    int base, dv;
    dv = exp_div(dbl, c[1:0]);
    acc(1'b1, ADDR_CONTROL, c, d, e);
    acc(1'b1, ADDR_STATUS, {7'h00, dbl}, d, e);
    m_clock_idle_polarity <= c[CTL_CLOCK_IDLE_POLARITY];
    m_clock_sample_phase <= c[CTL_CLOCK_SAMPLE_PHASE];
    m_lsb <= c[CTL_ORDER];
    m_tx <= sd;
    @(posedge sys_clk) load <= 1'b1;
    @(posedge sys_clk) load <= 1'b0;
    @(posedge sys_clk) base = tog;
    chk(pins.sck_oe_n, 1'b0);
    acc(1'b1, ADDR_DATA, tx, d, e);
    // A second write while shifting must be refused
    if (coll) acc(1'b1, ADDR_DATA, ~tx, d, e);
    for (int k = 0; k < 3000; k++) begin
      acc(1'b0, ADDR_STATUS, 8'h00, s, e);
      if (s[STS_TCF] === 1'b1) break;
    end
    chk(s, {1'b1, coll, 5'h00, dbl});
    chk(32'(tog - base), 32'd16);
    chk(32'(tt[base + 1] - tt[base]), 32'(dv / 2));
    chk(pins.sck_o, c[CTL_CLOCK_IDLE_POLARITY]);
    chk(m_rx, tx);
    chk(xfer_irq, c[CTL_IRQ_EN]);
    if (vec) begin
      @(posedge sys_clk) vector_taken <= 1'b1;
      @(posedge sys_clk) vector_taken <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(xfer_irq, 1'b0);
    end else begin
      acc(1'b0, ADDR_DATA, 8'h00, d, e);
      // The sync flops age the sample too much at the fastest rates
      if (dv >= 8) chk(d, sd);
    end
    acc(1'b0, ADDR_STATUS, 8'h00, s, e);
    chk(s[7:6], 2'b00);
    $display("Transfer done: control %0h div %0d", c, dv);
  endtask
  // One slave transfer clocked by the bench acting as the far master
  task slave_xfer(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] md);
    logic [7:0] got, s, d;
    logic e;
    int nb;
    got = 8'h00;
    acc(1'b1, ADDR_CONTROL, c, d, e);
    s_sck <= c[CTL_CLOCK_IDLE_POLARITY];
    s_mosi <= c[CTL_ORDER] ? md[0] : md[7];
    acc(1'b1, ADDR_DATA, tx, d, e);
    ss_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk(pins.miso_oe_n, 1'b0);
    for (int k = 0; k < 16; k++) begin
      // Five clocks a phase keeps the far clock under a quarter of ours
      s_sck <= ~s_sck;
      if ((k % 2) == int'(c[CTL_CLOCK_SAMPLE_PHASE])) begin
        // Sample edge: the port's bit has stood since the last setup edge
        got[c[CTL_ORDER] ? k / 2 : 7 - k / 2] = pins.miso_o;
      end else if ((k + 1) / 2 < 8) begin
        nb = (k + 1) / 2;
        s_mosi <= c[CTL_ORDER] ? md[nb] : md[7 - nb];
      end
      repeat (5) @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
    chk(got, tx);
    acc(1'b0, ADDR_STATUS, 8'h00, s, e);
    chk(s[7:1], 7'h40);
    acc(1'b0, ADDR_DATA, 8'h00, d, e);
    chk(d, md);
    ss_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(pins.miso_oe_n, 1'b1);
    acc(1'b0, ADDR_STATUS, 8'h00, s, e);
    chk(s[7:6], 2'b00);
    $display("Slave transfer done: control %0h", c);
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic e;
    int base;
    d = $urandom(64881);
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    acc(1'b0, ADDR_CONTROL, 8'h00, d, e);
    chk(d, CONTROL_RST);
    acc(1'b0, ADDR_STATUS, 8'h00, d, e);
    chk(d, 8'h00);
    acc(1'b0, 10'h004, 8'h00, d, e);
    chk(e, 1'b1);
    $display("Reset and map test done");
    // Master role but port disabled: nothing may move
    acc(1'b1, ADDR_CONTROL, 8'h10, d, e);
    base = tog;
    acc(1'b1, ADDR_DATA, 8'hA5, d, e);
    repeat (100) @(posedge sys_clk);
    chk(32'(tog - base), 32'd0);
    acc(1'b0, ADDR_STATUS, 8'h00, d, e);
    chk(d, 8'h00);
    $display("Disabled test done");
    // Every rate code with and without double speed, random modes
    global_irq_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      xfer({1'b1, 1'b1, 1'($urandom), 1'b1, 2'($urandom), i[1:0]}, i[2], 8'($urandom),
           8'($urandom), 1'b0, 1'b0);
    end
    xfer(8'hDD, 1'b0, 8'h81, 8'h3C, 1'b1, 1'b0);
    xfer(8'hD1, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b1);
    // Select driven low by another master while in master role
    acc(1'b1, ADDR_CONTROL, 8'h50, d, e);
    ss_n_i <= 1'b0;
    repeat (6) @(posedge sys_clk);
    acc(1'b0, ADDR_CONTROL, 8'h00, d, e);
    chk(d, 8'h40);
    chk(pins.sck_oe_n, 1'b1);
    acc(1'b0, ADDR_STATUS, 8'h00, d, e);
    chk(d[STS_TCF], 1'b1);
    ss_n_i <= 1'b1;
    $display("Mode fault test done");
    // Slave role, random modes, rate bits set to show they are ignored
    for (int i = 0; i < 3; i++) begin
      slave_xfer({2'b01, 1'($urandom), 1'b0, 2'($urandom), 2'b11}, 8'($urandom),
                 8'($urandom));
    end
    close_out;
  end
  // Watchdog: the longest run is well under a third of this span
  initial begin
    #5000000;
    fails++;
    close_out;
  end
endmodule
